// ==== rtl/aux_address_generator.sv ====
// Auxiliary register file, address arithmetic, data address select and move control
`timescale 1ns/10ps

module aux_address_generator
  import aux_addr_pkg::*;
#(
  parameter int unsigned XFER_CNT_W = aux_addr_pkg::CNT_W
)(
  // Clock and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         nrst_i,
  // Instruction decoder
  input  wire aux_addr_pkg::instr_type      instr_i,
  input  wire logic [15:0]                  prog_word_i,
  input  wire logic                         ar_load_i,
  input  wire logic [2:0]                   ar_load_idx_i,
  input  wire aux_addr_pkg::load_src_type   ar_load_src_i,
  input  wire logic                         arp_load_i,
  input  wire logic                         arp_load_src_i,
  input  wire logic                         page_load_i,
  input  wire logic                         ptr_save_i,
  input  wire logic                         ptr_restore_i,
  input  wire aux_addr_pkg::cmp_type        cmp_mode_i,
  input  wire logic                         shift_move_i,
  input  wire logic                         mac_move_i,
  input  wire logic                         ltd_move_i,
  // Data memory side
  input  wire logic [15:0]                  data_word_i,
  input  wire logic                         data_wr_i,
  input  wire logic [15:0]                  data_wdata_i,
  output logic [15:0]                       data_addr_o,
  output logic                              move_wr_o,
  output logic [15:0]                       move_addr_o,
  output logic [15:0]                       ar_store_o,
  output logic [15:0]                       mmr_rdata_o,
  output logic                              mmr_hit_o,
  output aux_addr_pkg::mmr_type             mmr_o,
  // Branch conditions and pointers
  output logic                              cmp_true_o,
  output logic                              ar_nonzero_o,
  output logic [2:0]                        arp_o,
  output logic [2:0]                        arb_o,
  // Block and table transfers
  input  wire logic                         xfer_start_i,
  input  wire aux_addr_pkg::xfer_kind_type  xfer_kind_i,
  input  wire logic [XFER_CNT_W-1:0]        xfer_count_i,
  input  wire logic                         prog_b0_i,
  output logic [15:0]                       xfer_addr_o,
  output logic                              xfer_rd_data_o,
  output logic                              xfer_rd_prog_o,
  output logic                              xfer_wr_prog_o,
  output logic                              xfer_busy_o,
  output logic                              xfer_refused_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
      r[i] = v[15-i];
    return r;
  endfunction : rev16

  function automatic logic in_ram(input logic [15:0] a);
    return ((a >= RAM_B2_LO) && (a <= RAM_B2_HI)) || ((a >= RAM_B01_LO) && (a <= RAM_B01_HI));
  endfunction : in_ram

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0]             ar_q [AR_NUM];
  logic [2:0]              arp_q;
  logic [2:0]              arb_q;
  logic [PAGE_W-1:0]       page_q;
  logic [15:0]             mmr_q [MMR_NUM];
  logic [15:0]             mmr_rdata_q;
  xfer_state_type          xs_q;
  xfer_kind_type           xkind_q;
  logic [15:0]             xaddr_q;
  logic [XFER_CNT_W-1:0]   xcnt_q;
  logic                    xref_q;

  // ----------------------------------------------------------------
  // Auxiliary arithmetic
  // ----------------------------------------------------------------
  wire logic [15:0] cur_ar    = ar_q[arp_q];
  wire logic [15:0] idx_ar    = ar_q[0];
  wire logic [15:0] imm8      = {8'h00, instr_i.word[IMM8_W-1:0]};
  wire logic [15:0] rc_sum    = rev16(rev16(cur_ar) + rev16(idx_ar));
  wire logic [15:0] rc_diff   = rev16(rev16(cur_ar) - rev16(idx_ar));
  logic [15:0]      ar_next;

  // Plain 16-bit adders wrap on their own; no carry leaves this unit
  always_comb
  begin
    case (instr_i.op)
      AUX_INC:     ar_next = cur_ar + 16'h0001;
      AUX_DEC:     ar_next = cur_ar - 16'h0001;
      AUX_ADD_IDX: ar_next = cur_ar + idx_ar;
      AUX_SUB_IDX: ar_next = cur_ar - idx_ar;
      AUX_ADD_IMM: ar_next = cur_ar + imm8;
      AUX_SUB_IMM: ar_next = cur_ar - imm8;
      AUX_ADD_RC:  ar_next = rc_sum;
      AUX_SUB_RC:  ar_next = rc_diff;
      AUX_HOLD:    ar_next = cur_ar;
      default:     ar_next = cur_ar;
    endcase
  end

  // Post-modify only when the selected register addressed the operand
  wire logic post_mod = instr_i.valid && instr_i.indirect;

  // ----------------------------------------------------------------
  // Loads of registers and pointer
  // ----------------------------------------------------------------
  logic [15:0] ar_load_val;
  always_comb
  begin
    case (ar_load_src_i)
      LD_DATA:  ar_load_val = data_word_i;
      LD_SHORT: ar_load_val = imm8;
      LD_LONG:  ar_load_val = prog_word_i;
      default:  ar_load_val = data_word_i;
    endcase
  end

  wire logic [2:0] arp_load_val = arp_load_src_i ? data_word_i[2:0] : instr_i.word[2:0];

  // Explicit load of the selected register beats its own post-modify
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < AR_NUM; i++)
        ar_q[i] <= AR_RESET;
    end
    else
    begin
      if (post_mod)
        ar_q[arp_q] <= ar_next;
      if (ar_load_i)
        ar_q[ar_load_idx_i] <= ar_load_val;
    end
  end

  wire logic [2:0] arp_d = ptr_restore_i ? arb_q : (arp_load_i ? arp_load_val : arp_q);

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      arp_q  <= 3'h0;
      arb_q  <= 3'h0;
      page_q <= 9'h000;
    end
    else
    begin
      arp_q <= arp_d;
      if (ptr_save_i)
        arb_q <= arp_q;
      if (page_load_i)
        page_q <= instr_i.word[PAGE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Data address select
  // ----------------------------------------------------------------
  wire logic [15:0] direct_addr = {page_q, instr_i.word[OFFS_W-1:0]};
  wire logic [15:0] indirect_addr = cur_ar;

  assign data_addr_o = instr_i.indirect ? indirect_addr : direct_addr;
  assign ar_store_o  = cur_ar;
  assign arp_o       = arp_q;
  assign arb_o       = arb_q;

  // ----------------------------------------------------------------
  // Branch conditions
  // ----------------------------------------------------------------
  logic cmp_res;
  always_comb
  begin
    case (cmp_mode_i)
      CMP_EQ:  cmp_res = (cur_ar == idx_ar);
      CMP_LT:  cmp_res = (cur_ar <  idx_ar);
      CMP_GT:  cmp_res = (cur_ar >  idx_ar);
      CMP_NE:  cmp_res = (cur_ar != idx_ar);
      default: cmp_res = 1'b0;
    endcase
  end

  assign cmp_true_o   = cmp_res;
  assign ar_nonzero_o = (cur_ar != 16'h0000);

  // ----------------------------------------------------------------
  // Data shift move
  // ----------------------------------------------------------------
  wire logic [15:0] move_dst  = data_addr_o + 16'h0001;
  wire logic        move_req  = instr_i.valid && (shift_move_i || mac_move_i || ltd_move_i);
  // Off-chip words and RAM edges are left alone; B0 to B1 is contiguous
  wire logic        move_ok   = in_ram(data_addr_o) && in_ram(move_dst);

  assign move_wr_o   = move_req && move_ok;
  assign move_addr_o = move_dst;

  // ----------------------------------------------------------------
  // Memory-mapped words
  // ----------------------------------------------------------------
  wire logic        mmr_hit  = (data_addr_o <= MMR_LAST_OFF);
  wire logic [2:0]  mmr_idx  = data_addr_o[2:0];
  wire logic [15:0] mmr_mask = (data_addr_o == MMR_IRQ_MSK_OFF) ? MMR_IRQ_MSK_MASK :
                               (data_addr_o == MMR_GMEM_OFF)    ? MMR_GMEM_MASK : 16'hFFFF;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < MMR_NUM; i++)
        mmr_q[i] <= MMR_RESET;
      mmr_rdata_q <= MMR_RESET;
    end
    else
    begin
      if (data_wr_i && mmr_hit)
        mmr_q[mmr_idx] <= data_wdata_i & mmr_mask;
      mmr_rdata_q <= mmr_hit ? mmr_q[mmr_idx] : 16'h0000;
    end
  end

  assign mmr_rdata_o = mmr_rdata_q;
  assign mmr_hit_o   = mmr_hit;
  assign mmr_o       = '{ser_rx:   mmr_q[0],
                         ser_tx:   mmr_q[1],
                         tim_cnt:  mmr_q[2],
                         tim_prd:  mmr_q[3],
                         irq_mask: mmr_q[4][5:0],
                         gmem:     mmr_q[5][7:0]};

  // ----------------------------------------------------------------
  // Block and table transfers
  // ----------------------------------------------------------------
  // Start address arrives as the long immediate that follows the opcode
  wire logic refuse_src = (xfer_kind_i == XF_DATA_BLK) && (prog_word_i <= MMR_LAST_OFF);
  wire logic refuse_dst = (xfer_kind_i == XF_TBL_WR) && prog_b0_i && (prog_word_i >= PROG_B0_LO);
  wire logic start_ok   = xfer_start_i && (xs_q == XS_IDLE) && !refuse_src && !refuse_dst;
  wire logic last_word  = (xcnt_q == '0);
  wire logic run        = (xs_q == XS_RUN);

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      xs_q    <= XS_IDLE;
      xkind_q <= XF_DATA_BLK;
      xaddr_q <= 16'h0000;
      xcnt_q  <= '0;
      xref_q  <= 1'b0;
    end
    else
    begin
      xref_q <= xfer_start_i && (xs_q == XS_IDLE) && (refuse_src || refuse_dst);
      case (xs_q)
        XS_IDLE:
        begin
          if (start_ok)
          begin
            xs_q    <= XS_RUN;
            xkind_q <= xfer_kind_i;
            xaddr_q <= prog_word_i;
            xcnt_q  <= xfer_count_i;
          end
        end
        XS_RUN:
        begin
          // One word per cycle; the repeat count says how many follow
          xaddr_q <= xaddr_q + 16'h0001;
          xcnt_q  <= xcnt_q - 1'b1;
          if (last_word)
            xs_q <= XS_IDLE;
        end
        default: xs_q <= XS_IDLE;
      endcase
    end
  end

  assign xfer_addr_o    = xaddr_q;
  assign xfer_busy_o    = run;
  assign xfer_refused_o = xref_q;
  assign xfer_rd_data_o = run && (xkind_q == XF_DATA_BLK || xkind_q == XF_TBL_WR);
  assign xfer_rd_prog_o = run && (xkind_q == XF_PROG_BLK || xkind_q == XF_TBL_RD);
  assign xfer_wr_prog_o = run && (xkind_q == XF_TBL_WR);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence inc_issue_s;
    instr_i.valid && instr_i.indirect && instr_i.op == AUX_INC && !ar_load_i && !ptr_restore_i && !arp_load_i;
  endsequence

  sequence xfer_start_s;
    start_ok && xfer_count_i == 8'h02;
  endsequence

  post_inc_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    inc_issue_s |=> ar_store_o == $past(ar_store_o) + 16'h0001)
    else $error("increment did not reach selected register");

  post_idx_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (post_mod && instr_i.op == AUX_ADD_IDX && arp_q != 3'h0 && !ar_load_i && arp_d == arp_q)
    |=> ar_store_o == $past(ar_store_o) + $past(idx_ar))
    else $error("index add wrong");

  rev_carry_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (post_mod && instr_i.op == AUX_ADD_RC && idx_ar == 16'h8000 && cur_ar == 16'h0000 && arp_q != 3'h0
     && !ar_load_i && arp_d == arp_q) |=> ar_store_o == 16'h8000)
    else $error("reverse carry step wrong");

  direct_addr_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !instr_i.indirect |-> data_addr_o[15:7] == page_q && data_addr_o[6:0] == instr_i.word[6:0])
    else $error("direct address not page and offset");

  indirect_addr_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    instr_i.indirect |-> data_addr_o == ar_q[arp_q])
    else $error("indirect address not selected register");

  ptr_save_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ptr_save_i |=> arb_o == $past(arp_o))
    else $error("pointer buffer missed save");

  move_range_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    move_wr_o |-> in_ram(move_addr_o) && in_ram(data_addr_o) && move_addr_o == data_addr_o + 16'h0001)
    else $error("shift move outside on-chip RAM");

  move_fire_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (instr_i.valid && mac_move_i && data_addr_o >= RAM_B01_LO && data_addr_o < RAM_B01_HI) |-> move_wr_o)
    else $error("MAC move did not shift");

  mmr_src_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (xfer_start_i && !xfer_busy_o && xfer_kind_i == XF_DATA_BLK && prog_word_i <= MMR_LAST_OFF)
    |=> xfer_refused_o && !xfer_busy_o)
    else $error("block copy from mapped words not refused");

  xfer_len_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    xfer_start_s |=> xfer_busy_o [*3] ##1 !xfer_busy_o)
    else $error("transfer length wrong");

  nonzero_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ar_nonzero_o == (ar_q[arp_q] != 16'h0000) && (cmp_mode_i != CMP_EQ || cmp_true_o == (cur_ar == ar_q[0])))
    else $error("branch condition wrong");

endmodule : aux_address_generator

// ==== rtl/aux_addr_pkg.sv ====
// Shared constants, enumerations and carriers of the auxiliary address generator
package aux_addr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned AR_NUM   = 8;
  localparam int unsigned ARP_W    = 3;
  localparam int unsigned PAGE_W   = 9;
  localparam int unsigned OFFS_W   = 7;
  localparam int unsigned IMM8_W   = 8;
  localparam int unsigned CNT_W    = 8;

  // ----------------------------------------------------------------
  // Memory-mapped words at the bottom of data space
  // ----------------------------------------------------------------
  localparam int unsigned  MMR_NUM        = 6;
  localparam logic [15:0]  MMR_SER_RX_OFF = 16'h0000;
  localparam logic [15:0]  MMR_SER_TX_OFF = 16'h0001;
  localparam logic [15:0]  MMR_TIM_CNT_OFF = 16'h0002;
  localparam logic [15:0]  MMR_TIM_PRD_OFF = 16'h0003;
  localparam logic [15:0]  MMR_IRQ_MSK_OFF = 16'h0004;
  localparam logic [15:0]  MMR_GMEM_OFF   = 16'h0005;
  localparam logic [15:0]  MMR_LAST_OFF   = 16'h0005;
  localparam logic [15:0]  MMR_IRQ_MSK_MASK = 16'h003F;
  localparam logic [15:0]  MMR_GMEM_MASK  = 16'h00FF;
  localparam logic [15:0]  MMR_RESET      = 16'h0000;

  // ----------------------------------------------------------------
  // On-chip RAM blocks in data space, program-space view of block zero
  // ----------------------------------------------------------------
  localparam logic [15:0] RAM_B2_LO   = 16'h0060;
  localparam logic [15:0] RAM_B2_HI   = 16'h007F;
  localparam logic [15:0] RAM_B01_LO  = 16'h0200;
  localparam logic [15:0] RAM_B01_HI  = 16'h03FF;
  localparam logic [15:0] PROG_B0_LO  = 16'hFF00;
  localparam logic [15:0] AR_RESET    = 16'h0000;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    AUX_HOLD    = 4'b0000,
    AUX_INC     = 4'b0001,
    AUX_DEC     = 4'b0010,
    AUX_ADD_IDX = 4'b0011,
    AUX_SUB_IDX = 4'b0100,
    AUX_ADD_IMM = 4'b0101,
    AUX_SUB_IMM = 4'b0110,
    AUX_ADD_RC  = 4'b0111,
    AUX_SUB_RC  = 4'b1000
  } aux_op_type;

  typedef enum logic [1:0] {
    CMP_EQ = 2'b00,
    CMP_LT = 2'b01,
    CMP_GT = 2'b10,
    CMP_NE = 2'b11
  } cmp_type;

  typedef enum logic [1:0] {
    LD_DATA  = 2'b00,
    LD_SHORT = 2'b01,
    LD_LONG  = 2'b10
  } load_src_type;

  typedef enum logic [1:0] {
    XF_DATA_BLK = 2'b00,
    XF_PROG_BLK = 2'b01,
    XF_TBL_RD   = 2'b10,
    XF_TBL_WR   = 2'b11
  } xfer_kind_type;

  typedef enum logic [0:0] {
    XS_IDLE = 1'b0,
    XS_RUN  = 1'b1
  } xfer_state_type;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        indirect;
    aux_op_type  op;
    logic [15:0] word;
  } instr_type;

  typedef struct packed {
    logic [15:0] ser_rx;
    logic [15:0] ser_tx;
    logic [15:0] tim_cnt;
    logic [15:0] tim_prd;
    logic [5:0]  irq_mask;
    logic [7:0]  gmem;
  } mmr_type;

endpackage : aux_addr_pkg

// ==== bench/data_mem_model.sv ====
// Data memory model facing the address generator
`timescale 1ns/10ps
module data_mem_model (
  // Clock
  input  wire logic        core_clk_i,
  // Memory port
  input  wire logic [15:0] addr_i,
  input  wire logic        move_wr_i,
  input  wire logic [15:0] move_addr_i,
  output logic [15:0]      rdata_o
);
  logic [15:0] mem [1024];
  // --------------------
  // Storage
  // --------------------
  initial for (int i = 0; i < 1024; i++) mem[i] = ~16'(i);
  // Only on-chip words take a copy
  always @(posedge core_clk_i)
    if (move_wr_i && move_addr_i < 16'h0400) mem[move_addr_i[9:0]] <= mem[addr_i[9:0]];
  // Mapped words stay in the device, so the pattern here never reaches them
  assign rdata_o = addr_i < 16'h0400 ? mem[addr_i[9:0]] : ~addr_i;
endmodule : data_mem_model

// ==== bench/testbench.sv ====
// Self-checking bench for the auxiliary address generator
`timescale 1ns/10ps
module testbench;
  import aux_addr_pkg::*;
  // --------------------
  // Signals and reference state
  // --------------------
  logic core_clk_i, nrst_i, ar_load_i, arp_load_i, arp_load_src_i, page_load_i, ptr_save_i, ptr_restore_i;
  logic shift_move_i, mac_move_i, ltd_move_i, data_wr_i, xfer_start_i, prog_b0_i;
  logic mmr_hit_o, xfer_rd_data_o, xfer_rd_prog_o, xfer_wr_prog_o;
  logic move_wr_o, cmp_true_o, ar_nonzero_o, xfer_busy_o, xfer_refused_o;
  logic [15:0] prog_word_i, data_word_i, data_wdata_i, data_addr_o, move_addr_o, ar_store_o, mmr_rdata_o, xfer_addr_o;
  logic [2:0] ar_load_idx_i, arp_o, arb_o, p, b;
  logic [7:0] xfer_count_i;
  instr_type instr_i;
  load_src_type ar_load_src_i;
  cmp_type cmp_mode_i;
  xfer_kind_type xfer_kind_i;
  mmr_type mmr_o;
  logic [15:0] ar [8];
  logic [15:0] got, wd, mx;
  logic [19:0] e;
  logic [19:0] q [$];
  logic [15:0] mva [7] = '{16'h0200, 16'h02FF, 16'h007F, 16'h0400, 16'h0060, 16'h03FF, 16'h1234};
  integer seed = 32'he8ec;
  int n_mismatch, checked;

  aux_address_generator dut (.core_clk_i, .nrst_i, .instr_i, .prog_word_i, .ar_load_i, .ar_load_idx_i, .ar_load_src_i,
    .arp_load_i, .arp_load_src_i, .page_load_i, .ptr_save_i, .ptr_restore_i, .cmp_mode_i, .shift_move_i, .mac_move_i,
    .ltd_move_i, .data_word_i, .data_wr_i, .data_wdata_i, .data_addr_o, .move_wr_o, .move_addr_o, .ar_store_o,
    .mmr_rdata_o, .mmr_hit_o, .mmr_o, .cmp_true_o, .ar_nonzero_o, .arp_o, .arb_o, .xfer_start_i, .xfer_kind_i,
    .xfer_count_i, .prog_b0_i, .xfer_addr_o, .xfer_rd_data_o, .xfer_rd_prog_o, .xfer_wr_prog_o, .xfer_busy_o,
    .xfer_refused_o);
  data_mem_model mem (.core_clk_i, .addr_i(data_addr_o), .move_wr_i(move_wr_o), .move_addr_i(move_addr_o),
    .rdata_o(data_word_i));

  // --------------------
  // Reference arithmetic and scoreboard
  // --------------------
  function automatic logic [15:0] rv(input logic [15:0] a);
    for (int i = 0; i < 16; i++) rv[i] = a[15-i];
  endfunction : rv

  function automatic logic [15:0] calc(input aux_op_type op, input logic [15:0] a, x, w);
    case (op)
      AUX_INC: calc = a + 16'h0001;
      AUX_DEC: calc = a - 16'h0001;
      AUX_ADD_IDX: calc = a + x;
      AUX_SUB_IDX: calc = a - x;
      AUX_ADD_IMM: calc = a + {8'h00, w[7:0]};
      AUX_SUB_IMM: calc = a - {8'h00, w[7:0]};
      AUX_ADD_RC: calc = rv(rv(a) + rv(x));
      AUX_SUB_RC: calc = rv(rv(a) - rv(x));
      default: calc = a;
    endcase
  endfunction : calc

  function automatic logic inram(input logic [15:0] a);
    inram = (a >= RAM_B2_LO && a <= RAM_B2_HI) || (a >= RAM_B01_LO && a <= RAM_B01_HI);
  endfunction : inram

  function automatic logic [15:0] obs(input logic [3:0] s);
    case (s)
      3'h0: obs = data_addr_o;
      3'h1: obs = ar_store_o;
      3'h2: obs = {10'h0, arb_o, arp_o};
      3'h3: obs = xfer_addr_o;
      3'h4: obs = mmr_rdata_o;
      3'h5: obs = {move_wr_o, mmr_hit_o, move_addr_o[13:0]};
      3'h6: obs = {14'h0, cmp_true_o, ar_nonzero_o};
      4'h8: obs = mmr_o.ser_rx;
      4'h9: obs = mmr_o.ser_tx;
      4'hA: obs = mmr_o.tim_cnt;
      4'hB: obs = mmr_o.tim_prd;
      4'hC: obs = {10'h0, mmr_o.irq_mask};
      4'hD: obs = {8'h0, mmr_o.gmem};
      default: obs = {11'h0, xfer_rd_data_o, xfer_rd_prog_o, xfer_wr_prog_o, xfer_busy_o, xfer_refused_o};
    endcase
  endfunction : obs

  task automatic ex(input logic [3:0] s, input logic [15:0] v);
    q.push_back({s, v});
  endtask : ex

  // Notes are checked just before the next rising edge lands its updates
  always @(posedge core_clk_i)
    while (q.size() > 0)
    begin
      e = q.pop_front();
      got = obs(e[19:16]);
      checked++;
      if (got !== e[15:0])
      begin
        n_mismatch++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e[15:0]);
      end
    end

  // --------------------
  // Drivers, all entered just after a falling edge
  // --------------------
  task automatic ld(input logic [2:0] i, input load_src_type s, input logic [15:0] v);
    instr_i = '{1'b0, 1'b0, AUX_HOLD, v};
    {ar_load_i, ar_load_idx_i, prog_word_i} = {1'b1, i, v};
    ar_load_src_i = s;
    // Strobe stays up between loads; the caller drops it
    @(negedge core_clk_i);
    ar[i] = (s == LD_LONG) ? v : (s == LD_SHORT) ? {8'h00, v[7:0]} : ~{9'h0, v[6:0]};
  endtask : ld

  task automatic sp(input logic [2:0] n, input logic sv, rs);
    instr_i = '{1'b0, 1'b0, AUX_HOLD, {13'h0, n}};
    // Data source reads word n, which the model holds inverted
    {arp_load_i, arp_load_src_i, ptr_save_i, ptr_restore_i} = {1'b1, n[1], sv, rs};
    @(negedge core_clk_i);
    {arp_load_i, ptr_save_i, ptr_restore_i} = 3'b000;
    {b, p} = {sv ? p : b, rs ? b : (n[1] ? ~n : n)};
    ex(2, {10'h0, b, p});
    ex(1, ar[p]);
  endtask : sp

  task automatic aux(input aux_op_type op, input cmp_type c, input logic [15:0] w);
    logic [15:0] a;
    a = ar[p];
    instr_i = '{1'b1, 1'b1, op, w};
    cmp_mode_i = c;
    ex(0, a);
    ex(6, {14'h0, (c == CMP_EQ) ? (a == ar[0]) : (c == CMP_LT) ? (a < ar[0]) : (c == CMP_GT) ? (a > ar[0]) :
      (a != ar[0]), a != 16'h0000});
    ar[p] = calc(op, a, ar[0], w);
    @(negedge core_clk_i);
    ex(1, ar[p]);
  endtask : aux

  task automatic dac(input logic [15:0] a, input logic wr, input logic [15:0] d, input logic [2:0] mk);
    logic [15:0] n;
    n = a + 16'h0001;
    instr_i = '{1'b0, 1'b0, AUX_HOLD, {7'h0, a[15:7]}};
    page_load_i = 1'b1;
    @(negedge core_clk_i);
    page_load_i = 1'b0;
    instr_i = '{1'b1, 1'b0, AUX_INC, {9'h0, a[6:0]}};
    {shift_move_i, mac_move_i, ltd_move_i, data_wr_i, data_wdata_i} = {mk, wr, d};
    ex(0, a);
    ex(5, {|mk && inram(a) && inram(n), (a <= MMR_LAST_OFF), n[13:0]});
    @(negedge core_clk_i);
    {shift_move_i, mac_move_i, ltd_move_i, data_wr_i} = 4'h0;
    ex(1, ar[p]);
  endtask : dac

  task automatic xf(input xfer_kind_type k, input logic [7:0] c, input logic [15:0] a, input logic b0, rf);
    logic [2:0] sb;
    sb = {k == XF_DATA_BLK || k == XF_TBL_WR, k == XF_PROG_BLK || k == XF_TBL_RD, k == XF_TBL_WR};
    {xfer_start_i, xfer_count_i, prog_word_i, prog_b0_i} = {1'b1, c, a, b0};
    xfer_kind_i = k;
    @(negedge core_clk_i);
    xfer_start_i = 1'b0;
    for (int j = 0; j <= int'(c) && !rf; j++)
    begin
      ex(7, {11'h0, sb, 2'b10});
      ex(3, a + 16'(j));
      @(negedge core_clk_i);
    end
    ex(7, {15'h0, rf});
    @(negedge core_clk_i);
    ex(7, 16'h0000);
  endtask : xf

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // --------------------
  // Clock, watchdog and main sequence
  // --------------------
  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  // Run needs well under a thousand cycles
  initial
  begin
    #500000;
    n_mismatch++;
    close_out();
  end

  initial
  begin
    {nrst_i, ar_load_i, arp_load_i, arp_load_src_i, page_load_i, ptr_save_i, ptr_restore_i} = '0;
    {shift_move_i, mac_move_i, ltd_move_i, data_wr_i, xfer_start_i, prog_b0_i, p, b} = '0;
    {prog_word_i, data_wdata_i, ar_load_idx_i, xfer_count_i, instr_i} = '0;
    ar_load_src_i = LD_LONG;
    cmp_mode_i = CMP_EQ;
    xfer_kind_i = XF_DATA_BLK;
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i);
    nrst_i = 1'b1;
    ex(1, AR_RESET);
    ex(2, 16'h0000);
    for (int i = 0; i < 8; i++) ld(3'(i), load_src_type'(i % 3), 16'($random(seed)));
    ar_load_i = 1'b0;
    for (int k = 0; k < 27; k++)
    begin
      sp(3'($random(seed)), k % 5 == 0, k % 7 == 3);
      aux(aux_op_type'(k % 9), cmp_type'(k % 4), 16'($random(seed)));
      aux(aux_op_type'((k + 4) % 9), cmp_type'(3 - k % 4), 16'($random(seed)));
    end
    ld(3'h0, LD_LONG, 16'h8000);
    ld(3'h1, LD_LONG, 16'h0000);
    ar_load_i = 1'b0;
    sp(3'h1, 1'b0, 1'b0);
    aux(AUX_ADD_RC, CMP_NE, 16'h0000);
    foreach (mva[i]) dac(mva[i], 1'b0, 16'h0000, 3'b001 << (i % 3));
    for (int i = 0; i < 7; i++)
    begin
      wd = 16'($random(seed));
      dac(16'(i), 1'b1, wd, 3'b000);
      dac(16'(i), 1'b0, 16'h0000, 3'b000);
      mx = i > 5 ? 16'h0000 : i == 4 ? wd & MMR_IRQ_MSK_MASK : i == 5 ? wd & MMR_GMEM_MASK : wd;
      ex(4, mx);
      if (i < 6) ex(4'(8 + i), mx);
    end
    xf(XF_DATA_BLK, 8'h02, 16'h0300, 1'b0, 1'b0);
    xf(XF_PROG_BLK, 8'h03, 16'hFF00, 1'b1, 1'b0);
    xf(XF_TBL_RD, 8'h00, 16'($random(seed)), 1'b0, 1'b0);
    xf(XF_TBL_WR, 8'h01, 16'h1000, 1'b1, 1'b0);
    xf(XF_DATA_BLK, 8'h01, 16'h0005, 1'b0, 1'b1);
    xf(XF_TBL_WR, 8'h00, 16'hFF10, 1'b1, 1'b1);
    @(negedge core_clk_i);
    close_out();
  end
endmodule : testbench
